// ==== core/mgc_pkg.sv ====
// Purpose: Shared constants and types for the mode global command block
// Assumes: 16-bit command frames, 10 MHz system clock
// Notes:   Register offsets are byte addresses on the Avalon-MM slave
package mgc_pkg;

    // Command word fields
    localparam logic [4:0]  MODE_ADDR      = 5'h0E;   // Mode register address, bits 13-9
    localparam logic [1:0]  KIND_READ      = 2'h0;    // bits 15-14 of the random code read
    localparam logic [1:0]  KIND_WRITE     = 2'h1;    // bits 15-14 of a mode write
    localparam logic [1:0]  KIND_DBG       = 2'h3;    // bits 15-14 of the safe/debug read
    localparam logic [15:0] CMD_WD_REFRESH = 16'h5A00;
    localparam logic [4:0]  MODE_NREQ_VAL  = 5'h02;   // Mode write value for normal request

    // Reported mode codes
    localparam logic [4:0]  CODE_INIT      = 5'h00;
    localparam logic [4:0]  CODE_PROG      = 5'h01;
    localparam logic [4:0]  CODE_NREQ      = 5'h02;
    localparam logic [4:0]  CODE_NORMAL    = 5'h03;

    // Avalon register byte offsets
    localparam logic [3:0]  OFS_CTRL       = 4'h0;
    localparam logic [3:0]  OFS_STATUS     = 4'h4;
    localparam logic [3:0]  OFS_FIXBYTE    = 4'h8;
    localparam logic [3:0]  OFS_LASTCMD    = 4'hC;
    localparam int          CTRL_RND_BIT   = 7;       // Random code entry enable position

    // Values after reset
    localparam logic [2:0]  RND_SEED       = 3'h5;
    localparam logic [7:0]  FIXBYTE_RST    = 8'h00;
    localparam logic [1:0]  STRAP_WAIT     = 2'h3;    // Cycles until the strap sync is valid

    // Operating state, Gray along init, normal, low power, normal request
    typedef enum logic [1:0] {
        MGC_ST_INIT   = 2'b00,
        MGC_ST_NORMAL = 2'b01,
        MGC_ST_LP     = 2'b11,
        MGC_ST_NREQ   = 2'b10
    } mgc_state_t;

    // One received frame
    typedef struct packed {
        logic [1:0] kind;
        logic [4:0] addr;
        logic       glob;
        logic [7:0] data;
    } mgc_cmd_t;

    // Low power selection outputs
    typedef struct packed {
        logic regulator_down;
        logic forced_wakeup;
        logic cyclic_sense;
    } mgc_lp_t;

endpackage

// ==== core/mgc_spi_rx.sv ====
// Purpose: 16-bit SPI slave framer, mode 0, oversampled by the system clock
// Assumes: SCLK at most about 1 MHz so every edge is seen after synchronising
// Notes:   High response byte loads at frame start, low byte after bit 8
`timescale 1ns/1ps
module mgc_spi_rx (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                ce,
    input  wire logic                spi_sclk,
    input  wire logic                spi_cs_n,
    input  wire logic                spi_mosi,
    output logic                     spi_miso,
    output logic                     spi_miso_oe,
    input  wire logic [7:0]          tx_hi,
    input  wire logic [7:0]          tx_lo,
    output logic                     hi_done,
    output logic [7:0]               hi_byte,
    output logic                     frame_done,
    output mgc_pkg::mgc_cmd_t        frame
);
    logic [2:0]  s1_q, s2_q;
    logic        sclk_d1_q, cs_d1_q;
    logic [15:0] rx_q;
    logic [4:0]  cnt_q;
    logic [7:0]  out_q, lo_q;
    logic        rise, fall, start, stop;

    // Two-stage synchronisers for sclk, cs_n and mosi
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 3'h2;
            s2_q <= 3'h2;
        end else if (ce) begin
            s1_q <= {spi_sclk, spi_cs_n, spi_mosi};
            s2_q <= s1_q;
        end
    end

    // Edge history on the second stage only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d1_q <= 1'b0;
            cs_d1_q   <= 1'b1;
        end else if (ce) begin
            sclk_d1_q <= s2_q[2];
            cs_d1_q   <= s2_q[1];
        end
    end

    assign rise  = ce && !s2_q[1] && s2_q[2] && !sclk_d1_q;
    assign fall  = ce && !s2_q[1] && !s2_q[2] && sclk_d1_q;
    assign start = ce && !s2_q[1] && cs_d1_q;
    assign stop  = ce && s2_q[1] && !cs_d1_q;

    // Receive shifter and bit counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_q  <= 16'h0000;
            cnt_q <= 5'h00;
        end else if (start) begin
            cnt_q <= 5'h00;
        end else if (rise) begin
            rx_q  <= {rx_q[14:0], s2_q[0]};
            cnt_q <= (cnt_q == 5'h1F) ? cnt_q : cnt_q + 5'h01;
        end
    end

    assign hi_byte = {rx_q[6:0], s2_q[0]};
    assign hi_done = rise && (cnt_q == 5'h07);

    // Transmit shifter; low byte is captured as the 8th bit lands
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= 8'h00;
            lo_q  <= 8'h00;
        end else if (start) begin
            out_q <= tx_hi;
        end else if (hi_done) begin
            lo_q  <= tx_lo;
        end else if (fall) begin
            out_q <= (cnt_q == 5'h08) ? lo_q : {out_q[6:0], 1'b0};
        end
    end

    // Frame completes only on exactly 16 clocks; other lengths are dropped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_done <= 1'b0;
            frame      <= '0;
        end else if (ce) begin
            frame_done <= stop && (cnt_q == 5'h10);
            if (stop) begin
                frame.kind <= rx_q[15:14];
                frame.addr <= rx_q[13:9];
                frame.glob <= rx_q[8];
                frame.data <= rx_q[7:0];
            end
        end
    end

    assign spi_miso    = out_q[7];
    assign spi_miso_oe = !s2_q[1];
endmodule

// ==== core/mgc_mode_top.sv ====
// Purpose: Mode register global commands and random code low power entry
// Assumes: SPI master sends 16-bit words; Avalon-MM host owns the startup option
// Notes:   Regulators, watchdog, CAN and wake sources live outside this block
// What this block does
// - In normal mode 0x1D00 or 0x1D80 returns the current random code in the answer.
// - The three random code bits go out on answer bits 2, 1 and 0.
// - Without random code, 0x5C60 enters regulator-off low power with no sensing or wakeup timer.
// - Command 1D00 reports the mode, leaves debug and keeps the fail-safe pin.
// - Command 1D80 reports mode and random code and releases the fail-safe pin.
// - Command DD00 leaves debug, keeps the pin, answers fail-safe in bit 1 and debug in bit 0.
// - Command DD80 keeps debug, releases the pin and answers mode plus both status bits.
// - Answer bits 7-3 give the mode: 0 init, 1 programming, 2 normal request, 3 normal, 1xxxx low power.
// - The fail-safe bit reads 0 while the pin driver is active and 1 once released.
// - The debug bit reads 0 when debug is off and 1 when debug is active.
// - Every global mode command carries bit 8 set beside address bits 13-9.
// - Pending wake flags at low power entry make the device enter and wake at once.
//
// Implementation choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module mgc_mode_top (
    input  wire logic           clk,
    input  wire logic           rstn,
    input  wire logic           ce,
    input  wire logic           spi_sclk,
    input  wire logic           spi_cs_n,
    input  wire logic           spi_mosi,
    output logic                spi_miso,
    output logic                spi_miso_oe,
    input  wire logic           debug_strap,
    input  wire logic           wake_pending,
    output logic                safe_drive,
    output logic                debug_active,
    output logic [4:0]          mode_code,
    output mgc_pkg::mgc_lp_t    low_power,
    input  wire logic [3:0]     avs_address,
    input  wire logic           avs_read,
    input  wire logic           avs_write,
    input  wire logic [31:0]    avs_writedata,
    input  wire logic [3:0]     avs_byteenable,
    output logic [31:0]         avs_readdata,
    output logic                avs_waitrequest
);
    logic               rst_s1_q, rst_n_q;
    logic               hi_done, frame_done;
    logic [7:0]         hi_byte, tx_lo;
    mgc_pkg::mgc_cmd_t  cmd;
    mgc_pkg::mgc_state_t st_q;
    logic [4:0]         lp_sel_q;
    logic [2:0]         lfsr_q, rnd_rep_q;
    logic               rnd_en_q, safe_off_q, debug_q;
    logic               dbg_s1_q, dbg_s2_q;
    logic [1:0]         strap_cnt_q;
    logic [7:0]         fixbyte_q;
    logic [15:0]        lastcmd_q;
    logic               ack_q;
    logic               is_mode_glob, is_read, is_dbg, is_write, lp_req, code_ok;

    // Mode write value asks for a low power mode: regulator off or on
    function automatic logic is_lp(input logic [4:0] v);
        is_lp = v[4] || (v[4:2] == 3'b011);
    endfunction

    // Global command check: mode address, bit 8 set, bits 6-0 clear
    function automatic logic is_glob(input logic [4:0] a, input logic g, input logic [6:0] d);
        is_glob = (a == mgc_pkg::MODE_ADDR) && g && (d == 7'h00);
    endfunction

    // Reset release through two flip-flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    mgc_spi_rx u_spi (
        .clk         (clk),
        .rst_n       (rst_n_q),
        .ce          (ce),
        .spi_sclk    (spi_sclk),
        .spi_cs_n    (spi_cs_n),
        .spi_mosi    (spi_mosi),
        .spi_miso    (spi_miso),
        .spi_miso_oe (spi_miso_oe),
        .tx_hi       (fixbyte_q),
        .tx_lo       (tx_lo),
        .hi_done     (hi_done),
        .hi_byte     (hi_byte),
        .frame_done  (frame_done),
        .frame       (cmd)
    );

    // Reported mode code, low power carries its selection with a leading 1
    always_comb begin
        case (st_q)
            mgc_pkg::MGC_ST_INIT:   mode_code = mgc_pkg::CODE_INIT;
            mgc_pkg::MGC_ST_NORMAL: mode_code = mgc_pkg::CODE_NORMAL;
            mgc_pkg::MGC_ST_NREQ:   mode_code = mgc_pkg::CODE_NREQ;
            default:                mode_code = {1'b1, lp_sel_q[3:0]};
        endcase
    end

    // Low answer byte chosen once the first byte has arrived
    always_comb begin
        if (hi_byte[7:6] == mgc_pkg::KIND_READ && hi_byte[5:1] == mgc_pkg::MODE_ADDR && hi_byte[0]) begin
            tx_lo = {mode_code, lfsr_q};
        end else if (hi_byte[7:6] == mgc_pkg::KIND_DBG && hi_byte[5:1] == mgc_pkg::MODE_ADDR
                     && hi_byte[0]) begin
            tx_lo = {mode_code, 1'b0, safe_off_q, debug_q};
        end else begin
            tx_lo = 8'h00;
        end
    end

    // Free running random source; the value sent is held for the check
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            lfsr_q    <= mgc_pkg::RND_SEED;
            rnd_rep_q <= mgc_pkg::RND_SEED;
        end else if (ce) begin
            lfsr_q <= {lfsr_q[1:0], lfsr_q[2] ^ lfsr_q[1]};
            if (hi_done && hi_byte[7:6] == mgc_pkg::KIND_READ && hi_byte[5:0] == {mgc_pkg::MODE_ADDR, 1'b1}) begin
                rnd_rep_q <= lfsr_q;
            end
        end
    end

    // Frame decode
    assign is_mode_glob = is_glob(cmd.addr, cmd.glob, cmd.data[6:0]);
    assign is_read  = frame_done && cmd.kind == mgc_pkg::KIND_READ && is_mode_glob;
    assign is_dbg   = frame_done && cmd.kind == mgc_pkg::KIND_DBG && is_mode_glob;
    // Writes carry the parity bit in bit 8, so only globals test it
    assign is_write = frame_done && cmd.kind == mgc_pkg::KIND_WRITE
                      && cmd.addr == mgc_pkg::MODE_ADDR;
    assign code_ok  = !rnd_en_q || (cmd.data[2:0] == ~rnd_rep_q);
    assign lp_req   = is_write && is_lp(cmd.data[7:3]);

    // Operating state; low power only from normal, wake pending bounces out
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q     <= mgc_pkg::MGC_ST_INIT;
            lp_sel_q <= 5'h00;
        end else if (ce) begin
            case (st_q)
                mgc_pkg::MGC_ST_INIT: begin
                    if (frame_done && {cmd.kind, cmd.addr, cmd.glob, cmd.data} == mgc_pkg::CMD_WD_REFRESH) begin
                        st_q <= mgc_pkg::MGC_ST_NORMAL;
                    end
                end
                mgc_pkg::MGC_ST_NORMAL: begin
                    if (lp_req && code_ok) begin
                        st_q     <= mgc_pkg::MGC_ST_LP;
                        lp_sel_q <= cmd.data[7:3];
                    end
                end
                mgc_pkg::MGC_ST_LP: begin
                    if (wake_pending) begin
                        st_q <= mgc_pkg::MGC_ST_NREQ;
                    end else if (is_write && cmd.data[7:3] == mgc_pkg::MODE_NREQ_VAL) begin
                        st_q <= mgc_pkg::MGC_ST_NREQ;
                    end
                end
                default: begin
                    if (frame_done && {cmd.kind, cmd.addr, cmd.glob, cmd.data} == mgc_pkg::CMD_WD_REFRESH) begin
                        st_q <= mgc_pkg::MGC_ST_NORMAL;
                    end
                end
            endcase
        end
    end

    // Fail-safe pin: driven from reset, released by the bit 7 variants
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            safe_off_q <= 1'b0;
        end else if (ce && (is_read || is_dbg) && cmd.data[7]) begin
            safe_off_q <= 1'b1;
        end
    end

    // Debug strap synchroniser
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            dbg_s1_q <= 1'b0;
            dbg_s2_q <= 1'b0;
        end else if (ce) begin
            dbg_s1_q <= debug_strap;
            dbg_s2_q <= dbg_s1_q;
        end
    end

    // Debug caught from the strap once after release, cleared by bit 7 low
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            debug_q     <= 1'b0;
            strap_cnt_q <= 2'h0;
        end else if (ce) begin
            if (strap_cnt_q != mgc_pkg::STRAP_WAIT) begin
                strap_cnt_q <= strap_cnt_q + 2'h1;
                debug_q     <= dbg_s2_q;
            end else if ((is_read || is_dbg) && !cmd.data[7]) begin
                debug_q <= 1'b0;
            end
        end
    end

    // Low power pin selections registered from the state
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            low_power <= '0;
        end else if (ce) begin
            low_power.regulator_down <= st_q == mgc_pkg::MGC_ST_LP && !lp_sel_q[4];
            low_power.forced_wakeup  <= st_q == mgc_pkg::MGC_ST_LP
                                        && (lp_sel_q[4] ? lp_sel_q[3] : lp_sel_q[1]);
            low_power.cyclic_sense   <= st_q == mgc_pkg::MGC_ST_LP
                                        && (lp_sel_q[4] ? lp_sel_q[2] : lp_sel_q[0]);
        end
    end

    assign safe_drive   = !safe_off_q;
    assign debug_active = debug_q;

    // Last accepted frame, for software inspection
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            lastcmd_q <= 16'h0000;
        end else if (ce && frame_done) begin
            lastcmd_q <= {cmd.kind, cmd.addr, cmd.glob, cmd.data};
        end
    end

    // Avalon slave: one wait cycle, answer on the second cycle of a request
    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ack_q <= 1'b0;
        end else if (ce) begin
            ack_q <= (avs_read || avs_write) && !ack_q;
        end
    end

    // Register writes land at the accepting edge; random option only sticks in init
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rnd_en_q  <= 1'b0;
            fixbyte_q <= mgc_pkg::FIXBYTE_RST;
        end else if (ce && avs_write && ack_q && avs_byteenable[0]) begin
            if (avs_address == mgc_pkg::OFS_CTRL) begin
                if (st_q == mgc_pkg::MGC_ST_INIT) begin
                    rnd_en_q <= avs_writedata[mgc_pkg::CTRL_RND_BIT];
                end
            end else if (avs_address == mgc_pkg::OFS_FIXBYTE) begin
                fixbyte_q <= avs_writedata[7:0];
            end
        end
    end

    // Read data, unmapped offsets read zero
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            avs_readdata <= 32'h0000_0000;
        end else if (ce && avs_read && !ack_q) begin
            if (avs_address == mgc_pkg::OFS_CTRL) begin
                avs_readdata <= {24'h00_0000, rnd_en_q, 7'h00};
            end else if (avs_address == mgc_pkg::OFS_STATUS) begin
                avs_readdata <= {19'h0_0000, st_q, rnd_rep_q, mode_code, 1'b0, safe_off_q,
                                 debug_q};
            end else if (avs_address == mgc_pkg::OFS_FIXBYTE) begin
                avs_readdata <= {24'h00_0000, fixbyte_q};
            end else if (avs_address == mgc_pkg::OFS_LASTCMD) begin
                avs_readdata <= {16'h0000, lastcmd_q};
            end else begin
                avs_readdata <= 32'h0000_0000;
            end
        end
    end
endmodule

// ==== tb/mgc_mode_top_assertions.sv ====
// Purpose: Port-level checks on the mode global command block
// Assumes: One clock domain, rstn active low
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ps
module mgc_mode_chk (
    input wire logic             clk,
    input wire logic             rstn,
    input wire logic             ce,
    input wire logic             spi_cs_n,
    input wire logic             spi_miso_oe,
    input wire logic             wake_pending,
    input wire logic             safe_drive,
    input wire logic             debug_active,
    input wire logic [4:0]       mode_code,
    input wire mgc_pkg::mgc_lp_t low_power,
    input wire logic             avs_read,
    input wire logic             avs_write,
    input wire logic             avs_waitrequest
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // Avalon answer: one wait cycle, then the accepting edge
    sequence s_one_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    // Command effects only land once the synchronised select is high
    sequence s_frame_over;
        $past(spi_cs_n, 2) && spi_cs_n;
    endsequence

    property p_rst_vals;
        $rose(rstn) |-> safe_drive && !debug_active && mode_code == 5'h00
            && low_power == 3'h0 && !spi_miso_oe;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("outputs not at reset values");

    property p_one_wait;
        $rose(avs_read || avs_write) && ce |-> s_one_wait;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("avalon wait not one cycle");

    property p_no_req;
        !(avs_read || avs_write) |-> !avs_waitrequest;
    endproperty
    a_no_req: assert property (p_no_req) else $error("waitrequest without request");

    property p_safe_sticky;
        !safe_drive |=> !safe_drive;
    endproperty
    a_safe_sticky: assert property (p_safe_sticky) else $error("safe driver came back");

    property p_safe_by_cmd;
        $fell(safe_drive) |-> s_frame_over;
    endproperty
    a_safe_by_cmd: assert property (p_safe_by_cmd) else $error("safe released mid frame");

    property p_dbg_by_cmd;
        $fell(debug_active) |-> s_frame_over;
    endproperty
    a_dbg_by_cmd: assert property (p_dbg_by_cmd) else $error("debug left mid frame");

    property p_lp_from_normal;
        $rose(mode_code[4]) |-> $past(mode_code) == mgc_pkg::CODE_NORMAL;
    endproperty
    a_lp_from_normal: assert property (p_lp_from_normal) else $error("low power not from normal");

    property p_lp_fields;
        mode_code == 5'h1C |=> low_power == 3'b100;
    endproperty
    a_lp_fields: assert property (p_lp_fields) else $error("low power selection wrong");

    property p_wake;
        mode_code[4] && wake_pending && ce |=> mode_code == mgc_pkg::CODE_NREQ;
    endproperty
    a_wake: assert property (p_wake) else $error("no immediate wake");

    property p_mode_enc;
        !mode_code[4] |-> mode_code[3:2] == 2'b00;
    endproperty
    a_mode_enc: assert property (p_mode_enc) else $error("illegal mode code");

    property p_oe_idle;
        spi_cs_n [*5] |-> !spi_miso_oe;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("miso driven while deselected");
endmodule

bind mgc_mode_top mgc_mode_chk chk_u (
    .clk, .rstn, .ce, .spi_cs_n, .spi_miso_oe, .wake_pending, .safe_drive,
    .debug_active, .mode_code, .low_power, .avs_read, .avs_write, .avs_waitrequest
);

// ==== tb/mgc_spi_host.sv ====
// Purpose: SPI master model standing in for the host controller
// Assumes: Mode 0, MSB first, 16-bit words
// Notes:   Clock stands still between frames; MOSI flips once released
`timescale 1ns/1ps
module mgc_spi_host (
    input  wire logic clk,
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic miso
);
    localparam int HALF = 10; // 1 us half period, slow enough for the synchronisers

    // Idle levels at time zero
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    // One whole frame; answer bits are taken at each rising sclk
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        @(posedge clk);
        cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi <= w[i];
            repeat (HALF) @(posedge clk);
            sclk <= 1'b1;
            r[i] = miso;
            repeat (HALF) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (HALF) @(posedge clk);
        cs_n <= 1'b1;
        mosi <= ~mosi; // A stale bit must not pass for data
        repeat (2 * HALF) @(posedge clk);
    endtask
endmodule

// ==== tb/mgc_mode_top_tb.sv ====
// Purpose: Self-checking bench for the mode global command block
// Assumes: 10 MHz clock; SPI host model on the far side, Avalon host here
// Notes:   A second reset in mid-run brings back init so random entry can be set
`timescale 1ns/1ps
module mgc_mode_top_tb;
    logic             clk = 1'b0;
    logic             rstn = 1'b0;
    logic             wake_pending = 1'b0;
    logic [3:0]       avs_address = 4'h0;
    logic             avs_read = 1'b0;
    logic             avs_write = 1'b0;
    logic [31:0]      avs_writedata = 32'h0;
    logic [3:0]       avs_byteenable = 4'hF;
    logic [31:0]      avs_readdata;
    logic             avs_waitrequest;
    logic             sclk, cs_n, mosi, miso, miso_oe, safe_drive, debug_active;
    logic [4:0]       mode_code;
    mgc_pkg::mgc_lp_t low_power;
    int               errors = 0;
    int               n_compared = 0;
    logic [15:0]      r;
    logic [31:0]      d;
    logic [2:0]       c;
    wire              miso_w = miso_oe ? miso : 1'b1; // Pull-up while released

    always #50 clk = ~clk;

    // Clock enable stays high; the strap keeps debug on out of reset
    mgc_mode_top dut_u (
        .clk, .rstn, .ce(1'b1), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
        .spi_miso(miso), .spi_miso_oe(miso_oe), .debug_strap(1'b1), .wake_pending,
        .safe_drive, .debug_active, .mode_code, .low_power, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest
    );
    mgc_spi_host host_u (.clk, .sclk, .cs_n, .mosi, .miso(miso_w));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One Avalon transfer, held until waitrequest is seen low
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clk); while (avs_waitrequest);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic do_reset();
        @(posedge clk);
        rstn <= 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
    endtask

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Reset values, an unmapped place and a write with its lane disabled
    task automatic t_regs();
        chk("safe_drive", 1, safe_drive);
        chk("mode_code", 0, mode_code);
        av(0, mgc_pkg::OFS_CTRL, 0, d);
        chk("ctrl", 0, d);
        av(1, 4'h2, 32'hFF, d);
        av(0, 4'h2, 0, d);
        chk("unmapped", 0, d);
        av(1, mgc_pkg::OFS_FIXBYTE, 32'hA5, d);
        avs_byteenable <= 4'h0;
        av(1, mgc_pkg::OFS_FIXBYTE, 32'h3C, d);
        avs_byteenable <= 4'hF;
        av(0, mgc_pkg::OFS_FIXBYTE, 0, d);
        chk("fixbyte", 32'hA5, d);
        $display("t_regs done");
    endtask

    // Safe and debug commands in init; bit 2 of the answer is left open
    task automatic t_dbg();
        host_u.xfer(16'hDD80, r);
        chk("dd80 answer", 16'hA501, r & 16'hFFFB);
        chk("safe after dd80", 0, safe_drive);
        chk("debug after dd80", 1, debug_active);
        host_u.xfer(16'hDD00, r);
        chk("dd00 answer", 16'hA503, r & 16'hFFFB);
        chk("debug after dd00", 0, debug_active);
        chk("safe after dd00", 0, safe_drive);
        $display("t_dbg done");
    endtask

    // Mode walk without random code, including a pending wake
    task automatic t_modes();
        host_u.xfer(mgc_pkg::CMD_WD_REFRESH, r);
        chk("normal", 3, mode_code);
        av(1, mgc_pkg::OFS_CTRL, 32'h80, d);
        av(0, mgc_pkg::OFS_CTRL, 0, d);
        chk("ctrl outside init", 0, d);
        host_u.xfer(16'h1D80, r);
        chk("1d80 mode", 3, r[7:3]);
        host_u.xfer(16'h5C60, r);
        chk("lp mode", 5'h1C, mode_code);
        chk("lp selection", 3'b100, low_power);
        host_u.xfer(16'hDD00, r);
        chk("dd00 in lp", 16'hA5E2, r & 16'hFFFB);
        host_u.xfer(16'h5C10, r);
        host_u.xfer(16'h1D00, r);
        chk("1d00 nreq", 2, r[7:3]);
        host_u.xfer(mgc_pkg::CMD_WD_REFRESH, r);
        wake_pending <= 1'b1;
        host_u.xfer(16'h5C60, r);
        chk("wake at once", 2, mode_code);
        wake_pending <= 1'b0;
        $display("t_modes done");
    endtask

    // Random code entry: malformed globals, a wrong code, then the right one
    task automatic t_rnd();
        chk("safe after reset", 1, safe_drive);
        av(1, mgc_pkg::OFS_CTRL, 32'h80, d);
        av(0, mgc_pkg::OFS_CTRL, 0, d);
        chk("ctrl in init", 32'h80, d);
        host_u.xfer(16'hDC80, r);
        host_u.xfer(16'hDD81, r);
        chk("safe kept", 1, safe_drive);
        host_u.xfer(mgc_pkg::CMD_WD_REFRESH, r);
        host_u.xfer(16'h1D00, r);
        chk("1d00 mode", 3, r[7:3]);
        chk("debug left", 0, debug_active);
        chk("safe kept 1d00", 1, safe_drive);
        av(0, mgc_pkg::OFS_STATUS, 0, d);
        chk("status", {19'h0_0000, mgc_pkg::MGC_ST_NORMAL, r[2:0], 8'h18}, d);
        c = r[2:0];
        host_u.xfer({13'b0101110001100, c}, r);
        chk("wrong code", 3, mode_code);
        host_u.xfer(16'h1D80, r);
        chk("1d80 high byte", 0, r[15:8]);
        chk("safe released", 0, safe_drive);
        c = r[2:0];
        host_u.xfer({13'b0101110001100, ~c}, r);
        chk("lp by code", 5'h1C, mode_code);
        $display("t_rnd done");
    endtask

    // Watchdog: the full sequence needs well under a millisecond
    initial begin
        #3000000;
        errors++;
        $display("[FAIL] watchdog expected finish seen timeout");
        final_report();
    end

    initial begin
        do_reset();
        t_regs();
        t_dbg();
        t_modes();
        do_reset();
        t_rnd();
        final_report();
    end
endmodule
